// ==== tpr_top.sv ====
// Touch panel report mode engine with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module tpr_top
   import tpr_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   // AXI4-Lite write address and data
   input  wire logic [AXI_AW-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [AXI_DW-1:0] s_axi_wdata,
   input  wire logic [AXI_SW-1:0] s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [AXI_AW-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [AXI_DW-1:0]      s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Converter samples
   input  wire logic              sampleValid,
   input  wire tpr_sample_t       sampleIn,
   // Controller busy with other commands
   input  wire logic              cmdBusy,
   // Invert-select pins and their pad sense
   input  wire logic              xInvertSelectIn,
   input  wire logic              xInvertSelectDriven,
   input  wire logic              yInvertSelectIn,
   input  wire logic              yInvertSelectDriven,
   // Report stream to the serial link
   output logic                   reportValid,
   output tpr_report_t            reportData,
   input  wire logic              reportReady,
   // Indicator and interrupt
   output logic                   touchActiveIndicator,
   output logic                   irq
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [NUM_REGS-1:0] regSel(logic [AXI_AW-1:0] a);
      logic [NUM_REGS-1:0] s;
      s = '0;
      s[SEL_CTRL]  = (a[AXI_AW-1:2] == ADDR_CTRL[AXI_AW-1:2]);
      s[SEL_INTV]  = (a[AXI_AW-1:2] == ADDR_INTERVAL[AXI_AW-1:2]);
      s[SEL_STAT]  = (a[AXI_AW-1:2] == ADDR_STATUS[AXI_AW-1:2]);
      s[SEL_MASK]  = (a[AXI_AW-1:2] == ADDR_MASK[AXI_AW-1:2]);
      s[SEL_RPT]   = (a[AXI_AW-1:2] == ADDR_REPORT[AXI_AW-1:2]);
      s[SEL_STATE] = (a[AXI_AW-1:2] == ADDR_STATE[AXI_AW-1:2]);
      return s;
   endfunction

   function automatic logic [AXI_DW-1:0] mergeStrb(
      logic [AXI_DW-1:0] old, logic [AXI_DW-1:0] nw, logic [AXI_SW-1:0] st);
      logic [AXI_DW-1:0] r;
      r = old;
      for (int i = 0; i < AXI_SW; i++) begin
         if (st[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [AXIS_W-1:0] axisVal(logic [AXIS_W-1:0] raw,
                                                 logic inv);
      return inv ? ~raw : raw;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Declarations

   logic                  awHave_r;
   logic                  wHave_r;
   logic [AXI_AW-1:0]     awAddr_r;
   logic [AXI_DW-1:0]     wData_r;
   logic [AXI_SW-1:0]     wStrb_r;
   logic                  awready_r;
   logic                  wready_r;
   logic                  bvalid_r;
   logic [1:0]            bresp_r;
   logic                  arready_r;
   logic                  rvalid_r;
   logic [1:0]            rresp_r;
   logic [AXI_DW-1:0]     rdata_r;

   tpr_mode_t             mode_r;
   tpr_state_t            state_r;
   tpr_state_t            state_nxt;
   logic [INTERVAL_W-1:0] interval_r;
   logic [STAT_W-1:0]     status_r;
   logic [STAT_W-1:0]     status_nxt;
   logic [STAT_W-1:0]     mask_r;
   logic                  irq_r;

   logic                  pressed_r;
   logic [AXIS_W-1:0]     lastX_r;
   logic [AXIS_W-1:0]     lastY_r;
   tpr_report_t           lastRpt_r;
   logic                  reportValid_r;
   tpr_report_t           reportData_r;
   logic                  pendValid_r;
   tpr_report_t           pendData_r;

   logic [3:0]            pinSync;
   logic                  xInv;
   logic                  yInv;
   logic                  timerExpire;

   ////////////////////////////////////////////////////////////////////////
   // Pins: synchronise, then apply the pull-up of an undriven pad

   tpr_sync2 #(
      .W (4)
   ) u_pin_sync (
      .clk   (clk),
      .reset (reset),
      .d     ({xInvertSelectIn, xInvertSelectDriven,
               yInvertSelectIn, yInvertSelectDriven}),
      .q     (pinSync)
   );

   // Undriven reads high, so only a driven low inverts
   assign xInv = pinSync[2] && !pinSync[3];
   assign yInv = pinSync[0] && !pinSync[1];

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   logic                  awTake;
   logic                  wTake;
   logic                  arTake;
   logic                  wrDo;
   logic [NUM_REGS-1:0]   wrSel;
   logic [NUM_REGS-1:0]   rdSel;
   logic                  cmdStrobe;
   tpr_mode_t             cmdMode;
   logic [AXI_DW-1:0]     intervalWord;
   logic [AXI_DW-1:0]     maskWord;
   logic [AXI_DW-1:0]     rptWord;
   logic [AXI_DW-1:0]     stateWord;
   logic [AXI_DW-1:0]     rdWord;

   assign awTake    = s_axi_awvalid && awready_r;
   assign wTake     = s_axi_wvalid && wready_r;
   assign arTake    = s_axi_arvalid && arready_r;
   assign wrDo      = awHave_r && wHave_r && !bvalid_r;
   assign wrSel     = wrDo ? regSel(awAddr_r) : '0;
   assign rdSel     = regSel(s_axi_araddr);
   assign cmdStrobe = wrSel[SEL_CTRL] && wStrb_r[0];
   // Unknown mode codes fall back to single report
   assign cmdMode   = (wData_r[MODE_W-1:0] > MODE_BOTH) ? MODE_SINGLE
                      : tpr_mode_t'(wData_r[MODE_W-1:0]);

   assign intervalWord = mergeStrb(AXI_DW'(interval_r), wData_r, wStrb_r);
   assign maskWord     = mergeStrb(AXI_DW'(mask_r), wData_r, wStrb_r);

   always_comb begin
      rptWord = '0;
      rptWord[RPT_FLAG_BIT] = lastRpt_r.touched;
      rptWord[RPT_X_LSB +: AXIS_W] = lastRpt_r.x;
      rptWord[RPT_Y_LSB +: AXIS_W] = lastRpt_r.y;
      stateWord = '0;
      stateWord[STATE_PRESSED_BIT] = pressed_r;
      stateWord[STATE_FSM_LSB +: $bits(state_r)] = state_r;
      stateWord[STATE_XINV_BIT] = xInv;
      stateWord[STATE_YINV_BIT] = yInv;
      stateWord[STATE_PEND_BIT] = pendValid_r;
   end

   assign rdWord = ({AXI_DW{rdSel[SEL_CTRL]}}  & AXI_DW'(mode_r))
                 | ({AXI_DW{rdSel[SEL_INTV]}}  & AXI_DW'(interval_r))
                 | ({AXI_DW{rdSel[SEL_STAT]}}  & AXI_DW'(status_r))
                 | ({AXI_DW{rdSel[SEL_MASK]}}  & AXI_DW'(mask_r))
                 | ({AXI_DW{rdSel[SEL_RPT]}}   & rptWord)
                 | ({AXI_DW{rdSel[SEL_STATE]}} & stateWord);

   ////////////////////////////////////////////////////////////////////////
   // Bus channels

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         awHave_r  <= 1'b0;
         wHave_r   <= 1'b0;
         awAddr_r  <= '0;
         wData_r   <= '0;
         wStrb_r   <= '0;
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= RESP_OKAY;
      end else begin
         if (awTake) begin
            awAddr_r <= s_axi_awaddr;
         end
         if (wTake) begin
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         awHave_r  <= (awHave_r || awTake) && !wrDo;
         wHave_r   <= (wHave_r || wTake) && !wrDo;
         awready_r <= !awHave_r && !awTake && !bvalid_r && !wrDo;
         wready_r  <= !wHave_r && !wTake && !bvalid_r && !wrDo;
         if (wrDo) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (regSel(awAddr_r) == '0) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= RESP_OKAY;
         rdata_r   <= '0;
      end else begin
         arready_r <= !arTake && !(rvalid_r && !s_axi_rready);
         if (arTake) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdWord;
            rresp_r  <= (rdSel == '0) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Touch tracking

   logic                  pressEdge;
   logic                  releaseEdge;
   tpr_report_t           pressRpt;
   tpr_report_t           releaseRpt;
   tpr_report_t           nowRpt;

   assign pressEdge   = sampleValid && sampleIn.pressed && !pressed_r;
   assign releaseEdge = sampleValid && !sampleIn.pressed && pressed_r;
   assign pressRpt    = '{touched: 1'b1,
                          x: axisVal(sampleIn.x, xInv),
                          y: axisVal(sampleIn.y, yInv)};
   // Release carries the values held at the moment of release
   assign releaseRpt  = '{touched: 1'b0, x: lastX_r, y: lastY_r};
   assign nowRpt      = pressed_r ? tpr_report_t'{1'b1, lastX_r, lastY_r}
                                  : '0;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pressed_r <= 1'b0;
         lastX_r   <= '0;
         lastY_r   <= '0;
      end else if (sampleValid) begin
         pressed_r <= sampleIn.pressed;
         if (sampleIn.pressed) begin
            lastX_r <= axisVal(sampleIn.x, xInv);
            lastY_r <= axisVal(sampleIn.y, yInv);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Report mode machine

   logic                  reqFire;
   tpr_report_t           reqData;
   logic                  periodic;

   assign periodic = (mode_r == MODE_AUTO) || (mode_r == MODE_WHILE);

   always_comb begin
      state_nxt = state_r;
      reqFire   = 1'b0;
      reqData   = nowRpt;
      if (cmdStrobe) begin
         // Single and auto commands report at once; the other modes wait for a press
         if (cmdMode == MODE_SINGLE) begin
            reqFire   = 1'b1;
            state_nxt = ST_STOP;
         end else if (cmdMode == MODE_AUTO) begin
            reqFire   = 1'b1;
            state_nxt = ST_RUN;
         end else begin
            state_nxt = ST_WAIT;
         end
      end else begin
         unique case (state_r)
            ST_STOP: begin
               state_nxt = ST_STOP;
            end
            ST_WAIT: begin
               if (pressEdge) begin
                  // Press mode stays armed here; the edge needs a release
                  reqFire   = (mode_r != MODE_RELEASE);
                  reqData   = pressRpt;
                  state_nxt = (mode_r == MODE_PRESS) ? ST_WAIT : ST_RUN;
               end
            end
            ST_RUN: begin
               if (mode_r == MODE_AUTO) begin
                  reqFire = timerExpire;
               end else if (releaseEdge) begin
                  reqFire   = 1'b1;
                  reqData   = releaseRpt;
                  state_nxt = ST_WAIT;
               end else if (mode_r == MODE_WHILE) begin
                  reqFire = timerExpire;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r <= ST_STOP;
         mode_r  <= MODE_SINGLE;
      end else begin
         state_r <= state_nxt;
         if (cmdStrobe) begin
            mode_r <= cmdMode;
         end
      end
   end

   // Busy controller holds the timer, stretching the gap
   tpr_interval_timer #(
      .CYC_PER_MS (CYC_PER_MS)
   ) u_timer (
      .clk        (clk),
      .reset      (reset),
      .clear      (reqFire || cmdStrobe || state_r != ST_RUN || !periodic),
      .hold       (cmdBusy),
      .intervalMs (interval_r),
      .expire     (timerExpire)
   );

   ////////////////////////////////////////////////////////////////////////
   // Report output with one pending slot

   logic                  outFree;
   logic                  rptTaken;
   logic                  dropEvt;

   assign outFree  = !reportValid_r || reportReady;
   assign rptTaken = reportValid_r && reportReady;
   assign dropEvt  = reqFire && pendValid_r && !outFree;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reportValid_r <= 1'b0;
         reportData_r  <= '0;
         pendValid_r   <= 1'b0;
         pendData_r    <= '0;
         lastRpt_r     <= '0;
      end else begin
         if (outFree) begin
            reportValid_r <= pendValid_r || reqFire;
            if (pendValid_r) begin
               reportData_r <= pendData_r;
               lastRpt_r    <= pendData_r;
               pendValid_r  <= reqFire;
               pendData_r   <= reqData;
            end else if (reqFire) begin
               reportData_r <= reqData;
               lastRpt_r    <= reqData;
            end
         end else if (reqFire) begin
            // Newest event replaces an unsent pending one
            pendValid_r <= 1'b1;
            pendData_r  <= reqData;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers, sticky status and interrupt

   logic [STAT_W-1:0]     statSet;
   logic [STAT_W-1:0]     statClr;

   assign statSet[STAT_SENT]    = rptTaken;
   assign statSet[STAT_PRESS]   = pressEdge;
   assign statSet[STAT_RELEASE] = releaseEdge;
   assign statSet[STAT_DROP]    = dropEvt;
   assign statClr    = (arTake && rdSel[SEL_STAT]) ? '1 : '0;
   // Set wins over the clearing read
   assign status_nxt = (status_r & ~statClr) | statSet;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         interval_r <= INTERVAL_RST;
         mask_r     <= MASK_RST;
         status_r   <= '0;
         irq_r      <= 1'b0;
      end else begin
         if (wrSel[SEL_INTV]) begin
            interval_r <= intervalWord[INTERVAL_W-1:0];
         end
         if (wrSel[SEL_MASK]) begin
            mask_r <= maskWord[STAT_W-1:0];
         end
         status_r <= status_nxt;
         irq_r    <= |(status_nxt & mask_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign s_axi_awready        = awready_r;
   assign s_axi_wready         = wready_r;
   assign s_axi_bvalid         = bvalid_r;
   assign s_axi_bresp          = bresp_r;
   assign s_axi_arready        = arready_r;
   assign s_axi_rvalid         = rvalid_r;
   assign s_axi_rresp          = rresp_r;
   assign s_axi_rdata          = rdata_r;
   assign reportValid          = reportValid_r;
   assign reportData           = reportData_r;
   assign touchActiveIndicator = pressed_r;
   assign irq                  = irq_r;

endmodule
`default_nettype wire

// ==== tpr_pkg.sv ====
// Constants, register map and types of the touch panel reporting block
package tpr_pkg;

   // Clock and timing
   localparam int CLK_HZ          = 125_000_000;
   localparam int MS_PER_S        = 1000;
   localparam int CYC_PER_MS_DEF  = CLK_HZ / MS_PER_S;
   localparam int INTERVAL_W      = 16;
   localparam int INTERVAL_DEF_MS = 50;
   localparam logic [INTERVAL_W-1:0] INTERVAL_RST = 16'h0032;

   // Bus geometry and answers
   localparam int AXI_AW = 8;
   localparam int AXI_DW = 32;
   localparam int AXI_SW = AXI_DW / 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register byte offsets
   localparam logic [AXI_AW-1:0] ADDR_CTRL     = 8'h00;
   localparam logic [AXI_AW-1:0] ADDR_INTERVAL = 8'h04;
   localparam logic [AXI_AW-1:0] ADDR_STATUS   = 8'h08;
   localparam logic [AXI_AW-1:0] ADDR_MASK     = 8'h0C;
   localparam logic [AXI_AW-1:0] ADDR_REPORT   = 8'h10;
   localparam logic [AXI_AW-1:0] ADDR_STATE    = 8'h14;
   localparam int NUM_REGS = 6;
   localparam int SEL_CTRL = 0;
   localparam int SEL_INTV = 1;
   localparam int SEL_STAT = 2;
   localparam int SEL_MASK = 3;
   localparam int SEL_RPT  = 4;
   localparam int SEL_STATE = 5;

   // Field positions
   localparam int AXIS_W       = 10;
   localparam int MODE_W       = 3;
   localparam int RPT_Y_LSB    = 0;
   localparam int RPT_X_LSB    = 16;
   localparam int RPT_FLAG_BIT = 31;
   localparam int STATE_PRESSED_BIT = 0;
   localparam int STATE_FSM_LSB     = 1;
   localparam int STATE_XINV_BIT    = 4;
   localparam int STATE_YINV_BIT    = 5;
   localparam int STATE_PEND_BIT    = 6;

   // Sticky status bits
   localparam int STAT_W       = 4;
   localparam int STAT_SENT    = 0;
   localparam int STAT_PRESS   = 1;
   localparam int STAT_RELEASE = 2;
   localparam int STAT_DROP    = 3;
   localparam logic [STAT_W-1:0] MASK_RST = 4'h0;

   typedef enum logic [MODE_W-1:0] {
      MODE_SINGLE  = 3'h0,
      MODE_AUTO    = 3'h1,
      MODE_WHILE   = 3'h2,
      MODE_PRESS   = 3'h3,
      MODE_RELEASE = 3'h4,
      MODE_BOTH    = 3'h5
   } tpr_mode_t;

   typedef enum logic [2:0] {
      ST_STOP = 3'b001,
      ST_WAIT = 3'b010,
      ST_RUN  = 3'b100
   } tpr_state_t;

   typedef struct packed {
      logic              pressed;
      logic [AXIS_W-1:0] x;
      logic [AXIS_W-1:0] y;
   } tpr_sample_t;

   typedef struct packed {
      logic              touched;
      logic [AXIS_W-1:0] x;
      logic [AXIS_W-1:0] y;
   } tpr_report_t;

endpackage

// ==== tpr_sync2.sv ====
// Two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module tpr_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Level in and out
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

// ==== tpr_interval_timer.sv ====
// Millisecond interval timer with hold input
`timescale 1ns/1ps
`default_nettype none
module tpr_interval_timer
   import tpr_pkg::*;
#(
   parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset,
   // Control
   input  wire logic                  clear,
   input  wire logic                  hold,
   input  wire logic [INTERVAL_W-1:0] intervalMs,
   // Expiry pulse
   output var  logic                  expire
);
   localparam int CYC_W = $clog2(CYC_PER_MS + 1);
   localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(CYC_PER_MS - 1);

   logic [CYC_W-1:0]      cyc_r;
   logic [INTERVAL_W-1:0] ms_r;
   logic [INTERVAL_W-1:0] target;
   logic                  msTick;
   logic                  done;

   // A zero interval behaves as one millisecond
   assign target = (intervalMs == '0) ? INTERVAL_W'(1) : intervalMs;
   assign msTick = !hold && (cyc_r == CYC_LAST);
   assign done   = msTick && (ms_r == target - INTERVAL_W'(1));

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cyc_r  <= '0;
         ms_r   <= '0;
         expire <= 1'b0;
      end else if (clear) begin
         cyc_r  <= '0;
         ms_r   <= '0;
         expire <= 1'b0;
      end else begin
         if (!hold) begin
            cyc_r <= msTick ? '0 : cyc_r + CYC_W'(1);
         end
         if (msTick) begin
            ms_r <= done ? '0 : ms_r + INTERVAL_W'(1);
         end
         expire <= done;
      end
   end
endmodule
`default_nettype wire

// ==== tpr_host_model.sv ====
// Host side report sink with stall control
`timescale 1ns/1ps
`default_nettype none
module tpr_host_model
   import tpr_pkg::*;
(
   // Clock and stall request
   input  wire logic         clk,
   input  wire logic         stall,
   // Report stream
   input  wire logic         reportValid,
   input  wire tpr_report_t  reportData,
   output logic              reportReady,
   // Reports seen
   output var  int           count,
   output var  tpr_report_t  last
);
   assign reportReady = !stall;
   initial count = 0;
   // Raw readings kept as sent, no screen mapping
   always @(posedge clk) begin
      if (reportValid && reportReady) begin
         count <= count + 1;
         last <= reportData;
      end
   end
endmodule
`default_nettype wire

// ==== tpr_top_asserts.sv ====
// Port checks of the touch report block
`timescale 1ns/1ps
`default_nettype none
module tpr_top_asserts
   import tpr_pkg::*;
(
   // Clock, reset and bus
   input wire logic clk, reset, s_axi_awready, s_axi_bvalid,
   input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [AXI_AW-1:0] s_axi_araddr,
   input wire logic [1:0]        s_axi_rresp,
   input wire logic [AXI_DW-1:0] s_axi_rdata,
   // Samples, reports, indicator
   input wire logic sampleValid, reportValid, reportReady,
   input wire logic touchActiveIndicator,
   input wire tpr_sample_t sampleIn,
   input wire tpr_report_t reportData
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_take; s_axi_arvalid && s_axi_arready; endsequence
   property p_rsp; s_take |=> s_axi_rvalid; endproperty
   a_rsp: assert property (p_rsp) else $error("read answer missing");
   property p_rerr;
      s_take ##0 (s_axi_araddr[AXI_AW-1:2] > ADDR_STATE[AXI_AW-1:2]) |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == '0; endproperty
   a_rerr: assert property (p_rerr) else $error("unmapped read accepted");
   property p_rend; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_rend: assert property (p_rend) else $error("read answer repeated");
   property p_arr; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_arr: assert property (p_arr) else $error("second read taken");
   property p_awr; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_awr: assert property (p_awr) else $error("second write taken");
   property p_ind; sampleValid |=>
      touchActiveIndicator == $past(sampleIn.pressed); endproperty
   a_ind: assert property (p_ind) else $error("indicator wrong");
   property p_indh; !sampleValid |=> $stable(touchActiveIndicator);
   endproperty
   a_indh: assert property (p_indh) else $error("indicator moved");
   property p_hold; reportValid && !reportReady |=>
      reportValid && $stable(reportData); endproperty
   a_hold: assert property (p_hold) else $error("report lost");
endmodule
bind tpr_top tpr_top_asserts u_chk (.*);
`default_nettype wire

// ==== tpr_top_bench.sv ====
// Self-checking bench of the touch report block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("mismatch %0t got %h exp %h", $time, a, e); end end
module tpr_top_bench
   import tpr_pkg::*;
;
   logic clk = 0, reset = 1, stall = 0, sampleValid = 0, cmdBusy = 0;
   logic xInvertSelectIn = 1, yInvertSelectIn = 1;
   logic xInvertSelectDriven = 0, yInvertSelectDriven = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, irq;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, reportValid, reportReady, touchActiveIndicator;
   logic [AXI_AW-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [AXI_DW-1:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [AXI_SW-1:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   tpr_sample_t sampleIn = '0;
   tpr_report_t reportData, last;
   int count, n_errors = 0, num_checks = 0;
   tpr_top #(.CYC_PER_MS(10)) dut (.*);
   tpr_host_model host (.*);
   always #4 clk = ~clk;
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, v};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (s_axi_rvalid !== 1'b1);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 0;
   endtask
   task automatic smp(input logic p, input logic [9:0] x, y);
      @(posedge clk);
      {sampleValid, sampleIn} <= {1'b1, p, x, y};
      @(posedge clk);
      sampleValid <= 0;
      repeat (3) @(posedge clk);
   endtask
   task automatic t_regs;
      rd(ADDR_INTERVAL);
      `CHK(d, 32'h0000_0032)
      wr(ADDR_INTERVAL, 32'h0000_0001);
      `CHK(r, RESP_OKAY)
      wr(8'h40, 32'h0000_0000);
      `CHK(r, RESP_SLVERR)
      rd(ADDR_INTERVAL);
      `CHK(d, 32'h0000_0001)
      rd(8'h40);
      `CHK(r, RESP_SLVERR)
      $display("done regs");
   endtask
   task automatic t_modes;
      int c;
      for (int m = 3; m <= 5; m++) begin
         wr(ADDR_CTRL, 32'(m));
         c = count;
         smp(1, 10'h2A5, 10'h15A);
         `CHK(touchActiveIndicator, 1'b1)
         smp(1, 10'h2A5, 10'h15A);
         smp(0, 10'h000, 10'h000);
         `CHK(touchActiveIndicator, 1'b0)
         `CHK(count - c, (m == 5) ? 2 : 1)
         `CHK(last, {m == 3, 10'h2A5, 10'h15A})
      end
      $display("done modes");
   endtask
   task automatic t_inv;
      int c;
      {xInvertSelectDriven, yInvertSelectDriven} <= 2'h3;
      {xInvertSelectIn, yInvertSelectIn} <= 2'h0;
      wr(ADDR_MASK, 32'h0000_0002);
      wr(ADDR_CTRL, 32'h0000_0003);
      stall <= 1;
      c = count;
      smp(1, 10'h2A5, 10'h15A);
      `CHK(count, c)
      `CHK(irq, 1'b1)
      stall <= 0;
      repeat (2) @(posedge clk);
      `CHK(last, {1'b1, 10'h15A, 10'h2A5})
      rd(ADDR_STATUS);
      `CHK(d, 32'h0000_0007)
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      rd(ADDR_REPORT);
      `CHK(d, 32'h815A_02A5)
      smp(0, 10'h000, 10'h000);
      {xInvertSelectDriven, yInvertSelectDriven} <= 2'h0;
      wr(ADDR_MASK, 32'h0000_0000);
      $display("done invert");
   endtask
   task automatic t_while;
      int c;
      wr(ADDR_CTRL, 32'h0000_0002);
      c = count;
      repeat (30) @(posedge clk);
      `CHK(count, c)
      smp(1, 10'h0F0, 10'h30F);
      repeat (30) @(posedge clk);
      `CHK(count - c > 2, 1'b1)
      cmdBusy <= 1;
      repeat (3) @(posedge clk);
      c = count;
      repeat (40) @(posedge clk);
      `CHK(count, c)
      cmdBusy <= 0;
      smp(0, 10'h000, 10'h000);
      `CHK(last, {1'b0, 10'h0F0, 10'h30F})
      c = count;
      repeat (30) @(posedge clk);
      `CHK(count, c)
      $display("done while");
   endtask
   task automatic t_single;
      int c;
      c = count;
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      `CHK(count - c, 1)
      `CHK(last, 21'h0_0000)
      c = count;
      wr(ADDR_CTRL, 32'h0000_0001);
      repeat (30) @(posedge clk);
      `CHK(count - c > 2, 1'b1)
      wr(ADDR_CTRL, 32'h0000_0000);
      repeat (3) @(posedge clk);
      c = count;
      repeat (30) @(posedge clk);
      `CHK(count, c)
      $display("done single");
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset <= 0;
      t_regs;
      t_modes;
      t_inv;
      t_while;
      t_single;
      finish_test;
   end
   initial begin
      #100_000;
      n_errors++;
      finish_test;
   end
endmodule
`default_nettype wire
